/* fpa_pkg.sv */
package fpa_pkg;
  localparam int unsigned CLK_HZ      = 100_000_000;
  localparam int unsigned CLK_NS      = 10;
  localparam int unsigned LONG_MS     = 2000;
  localparam int unsigned DEBOUNCE_MS = 20;
  localparam int unsigned FLASH_MS    = 250;
  localparam int unsigned LONG_CYC     = (LONG_MS * 1_000_000) / CLK_NS;
  localparam int unsigned DEBOUNCE_CYC = (DEBOUNCE_MS * 1_000_000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned FLASH_CYC    = (FLASH_MS * 1_000_000) / CLK_NS;

  localparam logic [31:0] ADDR_CTRL   = 32'h0000_0000;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
  localparam logic [31:0] ADDR_IRQ    = 32'h0000_0008;
  localparam logic [31:0] ADDR_MASK   = 32'h0000_000C;
  localparam logic [31:0] ADDR_MANOP  = 32'h0000_0010;
  localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
  localparam logic [31:0] MASK_RST    = 32'h0000_0000;

  // Control register fields
  localparam int unsigned C_DUAL     = 0;
  localparam int unsigned C_AMKEY_DIS = 1;
  localparam int unsigned C_RHKEY_DIS = 2;
  localparam int unsigned C_OP1_SOFT = 3;
  localparam int unsigned C_OP2_SOFT = 4;
  localparam int unsigned C_SEL_LP2  = 5;
  localparam int unsigned C_VIEW_LSB = 6;
  // Interrupt event bits
  localparam int unsigned I_ALARM    = 0;
  localparam int unsigned I_AMKEY    = 1;
  localparam int unsigned I_RUN      = 2;
  localparam int unsigned I_HOLD     = 3;
  localparam int unsigned I_RESET    = 4;
  localparam int unsigned I_PAGE     = 5;
  localparam int unsigned IRQ_W      = 6;

  typedef enum logic [1:0] {VIEW_DUAL, VIEW_LP1, VIEW_LP2, VIEW_OTHER} fpa_view_t;
  typedef enum {PG_IDLE, PG_RUN, PG_HELD, PG_END} fpa_profile_page_key_t;
endpackage : fpa_pkg

/* fpa_front_panel.sv */
`timescale 1ns/10ps
`default_nettype none
module fpa_front_panel
  import fpa_pkg::*;
#(
  parameter int unsigned LONG_CYCLES     = LONG_CYC,
  parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC,
  parameter int unsigned FLASH_CYCLES    = FLASH_CYC,
  parameter int unsigned PW              = 16
)(
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [31:0]   s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [31:0]   s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  input  wire logic          loop_mode_key,
  input  wire logic          profile_start_pause_key,
  input  wire logic          profile_page_key,
  input  wire logic          ack_key,
  input  wire logic [1:0]    lp1_chan_out,
  input  wire logic [1:0]    lp2_chan_out,
  input  wire logic [1:0]    soft_src,
  input  wire logic          remote_sp_active,
  input  wire logic          alt_sp_active,
  input  wire logic          alarm_cond,
  input  wire logic          alarm_new,
  input  wire logic          profile_page_key_end,
  input  wire logic [2:0]    comms_active,
  input  wire logic [1:0]    mode_restore,
  input  wire logic          mode_restore_valid,
  input  wire logic [PW-1:0] lp1_algo_out,
  input  wire logic [PW-1:0] lp2_algo_out,
  output logic               output_one_lamp,
  output logic               output_two_lamp,
  output logic               open_loop_lamp,
  output logic               external_sp_lamp,
  output logic               alt_sp_lamp,
  output logic               alarm_lamp,
  output logic               alarm_msg,
  output logic               profile_active_lamp,
  output logic               profile_held_lamp,
  output logic               first_comms_lamp,
  output logic               second_comms_lamp,
  output logic               infrared_comms_lamp,
  output logic               profile_page_key_page_shown,
  output logic [1:0]         mode_store,
  output logic               mode_store_we,
  output logic [PW-1:0]      lp1_power,
  output logic [PW-1:0]      lp2_power,
  output logic               irq
);
  localparam int unsigned NK = 4;

  logic [31:0]     ctrl_ff;
  logic [IRQ_W-1:0] irq_ff;
  logic [IRQ_W-1:0] mask_ff;
  logic [PW-1:0]   man1_ff;
  logic [PW-1:0]   man2_ff;
  logic [1:0]      manual_ff;
  fpa_profile_page_key_t       profile_page_key_ff;
  logic            alarm_unack_ff;
  logic            flash_ff;
  logic [31:0]     flash_cnt_ff;
  logic [NK-1:0]   key_db_ff;
  logic [NK-1:0]   key_press;
  logic [31:0]     db_cnt_ff [NK];
  logic [31:0]     long_cnt_ff;
  logic            long_done_ff;
  logic            rh_release;
  logic            aw_got_ff;
  logic            w_got_ff;
  logic [31:0]     awaddr_ff;
  logic [31:0]     wdata_ff;
  logic [3:0]      wstrb_ff;
  logic [1:0]      last_mode_ff;
  logic            loaded_ff;
  logic [NK-1:0]   keys;
  fpa_view_t       view;
  logic [IRQ_W-1:0] ev;
  logic            rd_irq;
  logic            wr_go;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (st[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction : merge

  assign keys = {ack_key, profile_page_key, profile_start_pause_key, loop_mode_key};
  assign view = fpa_view_t'(ctrl_ff[C_VIEW_LSB +: 2]);

  // Debounce: key must hold a new level for the whole window
  always_ff @(posedge aclk)
  begin
    for (int k = 0; k < NK; k++)
    begin
      if (!aresetn)
      begin
        key_db_ff[k] <= 1'b0;
        db_cnt_ff[k] <= 32'h0000_0000;
      end
      else if (keys[k] == key_db_ff[k])
        db_cnt_ff[k] <= 32'h0000_0000;
      else if (db_cnt_ff[k] >= DEBOUNCE_CYCLES - 1)
      begin
        key_db_ff[k] <= keys[k];
        db_cnt_ff[k] <= 32'h0000_0000;
      end
      else
        db_cnt_ff[k] <= db_cnt_ff[k] + 32'h0000_0001;
    end
  end

  always_comb
  begin
    for (int k = 0; k < NK; k++)
      key_press[k] = (keys[k] != key_db_ff[k]) && (db_cnt_ff[k] >= DEBOUNCE_CYCLES - 1) && keys[k];
  end
  assign rh_release = (keys[1] != key_db_ff[1]) && (db_cnt_ff[1] >= DEBOUNCE_CYCLES - 1) && !keys[1];

  // Long press timed from the debounced press edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !key_db_ff[1])
    begin
      long_cnt_ff  <= 32'h0000_0000;
      long_done_ff <= 1'b0;
    end
    else if (!long_done_ff && long_cnt_ff >= LONG_CYCLES - 1)
      long_done_ff <= 1'b1;
    else if (!long_done_ff)
      long_cnt_ff <= long_cnt_ff + 32'h0000_0001;
  end

  // Programmer: short press acts on release so a long hold never starts it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      profile_page_key_ff <= PG_IDLE;
    else if (long_cnt_ff >= LONG_CYCLES - 1 && !long_done_ff && key_db_ff[1] && !ctrl_ff[C_RHKEY_DIS])
      profile_page_key_ff <= PG_IDLE;
    else if (rh_release && !long_done_ff && !ctrl_ff[C_RHKEY_DIS])
    begin
      unique case (profile_page_key_ff)
        PG_IDLE: profile_page_key_ff <= PG_RUN;
        PG_RUN:  profile_page_key_ff <= PG_HELD;
        PG_HELD: profile_page_key_ff <= PG_RUN;
        PG_END:  profile_page_key_ff <= PG_END;
      endcase
    end
    else if (profile_page_key_ff == PG_RUN && profile_page_key_end)
      profile_page_key_ff <= PG_END;
  end

  // Auto/manual with persistent store and restore at power-up
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      manual_ff <= 2'b00;
      loaded_ff <= 1'b0;
    end
    else if (!loaded_ff && mode_restore_valid)
    begin
      manual_ff <= mode_restore;
      loaded_ff <= 1'b1;
    end
    else if (key_press[0] && !ctrl_ff[C_AMKEY_DIS])
    begin
      if (ctrl_ff[C_DUAL] && (view == VIEW_LP2 || ctrl_ff[C_SEL_LP2]))
        manual_ff[1] <= !manual_ff[1];
      else
        manual_ff[0] <= !manual_ff[0];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      last_mode_ff  <= 2'b00;
      mode_store    <= 2'b00;
      mode_store_we <= 1'b0;
    end
    else
    begin
      last_mode_ff  <= manual_ff;
      mode_store    <= manual_ff;
      mode_store_we <= (manual_ff != last_mode_ff);
    end
  end

  // Manual value captured from the live output on entry: bumpless
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      man1_ff <= '0;
      man2_ff <= '0;
    end
    else
    begin
      if (manual_ff[0] && !last_mode_ff[0])
        man1_ff <= lp1_power;
      else if (wr_go && awaddr_ff == ADDR_MANOP && wstrb_ff[0])
        man1_ff <= wdata_ff[PW-1:0];
      if (manual_ff[1] && !last_mode_ff[1])
        man2_ff <= lp2_power;
      else if (wr_go && awaddr_ff == ADDR_MANOP && wstrb_ff[2])
        man2_ff <= wdata_ff[PW +: PW];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lp1_power <= '0;
      lp2_power <= '0;
    end
    else
    begin
      // Entry cycle keeps the last level; the captured value is not ready yet
      if (!manual_ff[0])
        lp1_power <= lp1_algo_out;
      else if (last_mode_ff[0])
        lp1_power <= man1_ff;
      if (!manual_ff[1])
        lp2_power <= lp2_algo_out;
      else if (last_mode_ff[1])
        lp2_power <= man2_ff;
    end
  end

  // Alarm acknowledge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      alarm_unack_ff <= 1'b0;
    else if (alarm_new)
      alarm_unack_ff <= 1'b1;
    else if (key_press[3])
      alarm_unack_ff <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flash_cnt_ff <= 32'h0000_0000;
      flash_ff     <= 1'b0;
    end
    else if (flash_cnt_ff >= FLASH_CYCLES - 1)
    begin
      flash_cnt_ff <= 32'h0000_0000;
      flash_ff     <= !flash_ff;
    end
    else
      flash_cnt_ff <= flash_cnt_ff + 32'h0000_0001;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      profile_page_key_page_shown <= 1'b0;
    else if (key_press[2])
      profile_page_key_page_shown <= 1'b1;
    else if (key_press[0])
      profile_page_key_page_shown <= 1'b0;
  end

  // Lamps
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      output_one_lamp     <= 1'b0;
      output_two_lamp     <= 1'b0;
      open_loop_lamp      <= 1'b0;
      external_sp_lamp    <= 1'b0;
      alt_sp_lamp         <= 1'b0;
      alarm_lamp          <= 1'b0;
      alarm_msg           <= 1'b0;
      profile_active_lamp <= 1'b0;
      profile_held_lamp   <= 1'b0;
      first_comms_lamp    <= 1'b0;
      second_comms_lamp   <= 1'b0;
      infrared_comms_lamp <= 1'b0;
    end
    else
    begin
      if (ctrl_ff[C_DUAL] && view == VIEW_LP2)
      begin
        output_one_lamp <= lp2_chan_out[0];
        output_two_lamp <= lp2_chan_out[1];
      end
      else
      begin
        output_one_lamp <= lp1_chan_out[0];
        output_two_lamp <= lp1_chan_out[1];
      end
      if (ctrl_ff[C_OP1_SOFT])
        output_one_lamp <= soft_src[0];
      if (ctrl_ff[C_OP2_SOFT])
        output_two_lamp <= soft_src[1];
      if (ctrl_ff[C_DUAL] && view == VIEW_LP2)
        open_loop_lamp <= manual_ff[1];
      else
        open_loop_lamp <= manual_ff[0];
      external_sp_lamp    <= remote_sp_active;
      alt_sp_lamp         <= alt_sp_active;
      alarm_lamp          <= alarm_unack_ff ? flash_ff : alarm_cond;
      alarm_msg           <= alarm_unack_ff;
      profile_active_lamp <= (profile_page_key_ff == PG_RUN) || (profile_page_key_ff == PG_END && flash_ff);
      profile_held_lamp   <= (profile_page_key_ff == PG_HELD);
      first_comms_lamp    <= comms_active[0] && flash_ff;
      second_comms_lamp   <= comms_active[1] && flash_ff;
      infrared_comms_lamp <= comms_active[2] && flash_ff;
    end
  end

  // Interrupt events; set wins over read-clear
  assign ev[I_ALARM] = alarm_new;
  assign ev[I_AMKEY] = key_press[0] && !ctrl_ff[C_AMKEY_DIS];
  assign ev[I_RUN]   = profile_page_key_ff == PG_RUN && profile_page_key_end;
  assign ev[I_HOLD]  = rh_release && !long_done_ff && !ctrl_ff[C_RHKEY_DIS];
  assign ev[I_RESET] = long_cnt_ff >= LONG_CYCLES - 1 && !long_done_ff && key_db_ff[1] && !ctrl_ff[C_RHKEY_DIS];
  assign ev[I_PAGE]  = key_press[2];
  assign rd_irq = s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_IRQ;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_ff <= '0;
    else
      irq_ff <= (rd_irq ? '0 : irq_ff) | ev;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= |(irq_ff & mask_ff);
  end

  // AXI4-Lite write: address and data in either order
  assign wr_go = aw_got_ff && w_got_ff && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_ff     <= 1'b0;
      w_got_ff      <= 1'b0;
      awaddr_ff     <= 32'h0000_0000;
      wdata_ff      <= 32'h0000_0000;
      wstrb_ff      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end
    else
    begin
      s_axi_awready <= !aw_got_ff && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_got_ff && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_ff == ADDR_CTRL || awaddr_ff == ADDR_MASK || awaddr_ff == ADDR_MANOP ||
                         awaddr_ff == ADDR_STATUS || awaddr_ff == ADDR_IRQ) ? 2'b00 : 2'b10;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_got_ff    <= 1'b0;
        w_got_ff     <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_ff <= CTRL_RST;
      mask_ff <= MASK_RST[IRQ_W-1:0];
    end
    else if (wr_go && awaddr_ff == ADDR_CTRL)
      ctrl_ff <= merge(ctrl_ff, wdata_ff, wstrb_ff);
    else if (wr_go && awaddr_ff == ADDR_MASK && wstrb_ff[0])
      mask_ff <= wdata_ff[IRQ_W-1:0];
  end

  // AXI4-Lite read, one cycle from address to data
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'b00;
        unique case (s_axi_araddr)
          ADDR_CTRL:   s_axi_rdata <= ctrl_ff;
          ADDR_STATUS: s_axi_rdata <= {24'h00_0000, 1'b0, alarm_unack_ff, manual_ff, 2'(profile_page_key_ff), 1'b0, loaded_ff};
          ADDR_IRQ:    s_axi_rdata <= {{(32-IRQ_W){1'b0}}, irq_ff};
          ADDR_MASK:   s_axi_rdata <= {{(32-IRQ_W){1'b0}}, mask_ff};
          ADDR_MANOP:  s_axi_rdata <= {man2_ff, man1_ff};
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule : fpa_front_panel
`default_nettype wire

/* fpa_props.sv */
`timescale 1ns/10ps
`default_nettype none
module fpa_props (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       remote_sp_active,
  input wire logic       alt_sp_active,
  input wire logic       external_sp_lamp,
  input wire logic       alt_sp_lamp,
  input wire logic       alarm_new,
  input wire logic       ack_key,
  input wire logic       alarm_msg,
  input wire logic [2:0] comms_active,
  input wire logic       first_comms_lamp,
  input wire logic       mode_store_we,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [1:0] up_ff;
  // Lamps lag their inputs by one edge, so the first edges after reset are skipped
  always_ff @(posedge aclk)
  begin
    up_ff <= aresetn ? {up_ff[0], 1'b1} : 2'b00;
  end
  ext_sp_a: assert property (up_ff[1] |-> external_sp_lamp == $past(remote_sp_active))
    else $error("remote setpoint lamp wrong");
  alt_sp_a: assert property (up_ff[1] |-> alt_sp_lamp == $past(alt_sp_active))
    else $error("alternative setpoint lamp wrong");
  alarm_set_a: assert property (up_ff[1] && alarm_new |-> ##[1:2] alarm_msg)
    else $error("alarm message not raised");
  alarm_hold_a: assert property ((!ack_key) [*8] ##0 alarm_msg |=> alarm_msg)
    else $error("alarm message dropped without acknowledge");
  comms_off_a: assert property (up_ff[1] && !$past(comms_active[0]) |-> !first_comms_lamp)
    else $error("comms lamp lit while idle");
  we_pulse_a: assert property (mode_store_we |=> !mode_store_we)
    else $error("mode store strobe too long");
  aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("write address ready too long");
  ar_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response held after taken");
endmodule : fpa_props
`default_nettype wire

/* fpa_operator.sv */
`timescale 1ns/10ps
`default_nettype none
module fpa_operator (
  input  wire logic aclk,
  output var logic  loop_mode_key,
  output var logic  profile_start_pause_key,
  output var logic  profile_page_key,
  output var logic  ack_key
);
  logic [3:0] keys = 4'h0;
  assign {ack_key, profile_page_key, profile_start_pause_key, loop_mode_key} = keys;
  // Contact bounce: one short blip before the real press
  task automatic press(input int k, input int hold);
    keys[k] <= 1'b1;
    @(posedge aclk);
    keys[k] <= 1'b0;
    @(posedge aclk);
    keys[k] <= 1'b1;
    repeat (hold) @(posedge aclk);
    keys[k] <= 1'b0;
  endtask : press
endmodule : fpa_operator
`default_nettype wire

/* front_panel_annunciator_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module front_panel_annunciator_bench;
  import fpa_pkg::*;
  localparam int DB = 4;
  logic        aclk = 1'b0;
  logic        aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, mode_restore_valid, mode_store_we, irq;
  logic        loop_mode_key, profile_start_pause_key, profile_page_key, ack_key, profile_page_key_end, profile_page_key_page_shown;
  logic        remote_sp_active, alt_sp_active, alarm_cond, alarm_new, output_one_lamp, output_two_lamp;
  logic        open_loop_lamp, external_sp_lamp, alt_sp_lamp, alarm_lamp, alarm_msg, profile_active_lamp;
  logic        profile_held_lamp, first_comms_lamp, second_comms_lamp, infrared_comms_lamp;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, lp1_chan_out, lp2_chan_out, soft_src, mode_restore, mode_store, rr;
  logic [2:0]  comms_active;
  logic [15:0] lp1_algo_out, lp2_algo_out, lp1_power, lp2_power;
  logic [4:0]  hi, lo;
  int          fail_count, tests_run;
  wire  [4:0]  v = {alarm_lamp, profile_active_lamp, first_comms_lamp, second_comms_lamp, infrared_comms_lamp};

  fpa_front_panel #(.LONG_CYCLES(50), .DEBOUNCE_CYCLES(DB), .FLASH_CYCLES(8)) fpa_front_panel_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .loop_mode_key, .profile_start_pause_key, .profile_page_key, .ack_key, .lp1_chan_out, .lp2_chan_out,
    .soft_src, .remote_sp_active, .alt_sp_active, .alarm_cond, .alarm_new, .profile_page_key_end, .comms_active,
    .mode_restore, .mode_restore_valid, .lp1_algo_out, .lp2_algo_out, .output_one_lamp, .output_two_lamp,
    .open_loop_lamp, .external_sp_lamp, .alt_sp_lamp, .alarm_lamp, .alarm_msg, .profile_active_lamp,
    .profile_held_lamp, .first_comms_lamp, .second_comms_lamp, .infrared_comms_lamp, .profile_page_key_page_shown,
    .mode_store, .mode_store_we, .lp1_power, .lp2_power, .irq);
  fpa_operator fpa_operator_inst (.aclk, .loop_mode_key, .profile_start_pause_key, .profile_page_key, .ack_key);

  always #5 aclk = ~aclk;

  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  task automatic stall(input int n);
    if (n >= 50)
    begin
      chk("handshake", 32'h0000_0001, 32'h0000_0000);
      summarize();
    end
  endtask : stall

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
        break;
    end
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
    stall(n);
    @(posedge aclk);
  endtask : wr

  task automatic rdr(input logic [31:0] a);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
        break;
    end
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    stall(n);
    @(posedge aclk);
  endtask : rdr

  task automatic kp(input int k, input int h);
    fpa_operator_inst.press(k, h);
    cyc(DB + 4);
  endtask : kp

  task automatic watch(input int n);
    hi = 5'h00;
    lo = 5'h00;
    repeat (n)
    begin
      @(posedge aclk);
      hi |= v;
      lo |= ~v;
    end
  endtask : watch

  task automatic t_restore;
    mode_restore <= 2'b01;
    mode_restore_valid <= 1'b1;
    cyc(1);
    mode_restore_valid <= 1'b0;
    cyc(3);
    rdr(ADDR_STATUS);
    chk("restored", 32'h0000_0011, rd & 32'h0000_0031);
    chk("man_single", 32'h0000_0001, open_loop_lamp);
    rdr(ADDR_CTRL);
    chk("ctrl_rst", CTRL_RST, rd);
    rdr(ADDR_MASK);
    chk("mask_rst", MASK_RST, rd);
    rdr(32'h0000_0040);
    chk("unmapped_resp", 32'h0000_0002, rr);
    chk("unmapped_data", 32'h0000_0000, rd);
    wr(32'h0000_0040, 32'h0000_0000);
    chk("wr_unmapped", 32'h0000_0002, rr);
  endtask : t_restore

  task automatic t_lamps;
    lp1_chan_out <= 2'b01;
    lp2_chan_out <= 2'b10;
    cyc(2);
    chk("op_single", 32'h0000_0001, {output_two_lamp, output_one_lamp});
    wr(ADDR_CTRL, 32'h0000_0081);
    chk("wr_okay", 32'h0000_0000, rr);
    cyc(2);
    chk("op_loop2", 32'h0000_0002, {output_two_lamp, output_one_lamp});
    chk("man_loop2", 32'h0000_0000, open_loop_lamp);
    wr(ADDR_CTRL, 32'h0000_0001);
    cyc(2);
    chk("op_dual", 32'h0000_0001, {output_two_lamp, output_one_lamp});
    chk("man_dual", 32'h0000_0001, open_loop_lamp);
    wr(ADDR_CTRL, 32'h0000_0018);
    soft_src <= 2'b10;
    cyc(2);
    chk("op_soft", 32'h0000_0002, {output_two_lamp, output_one_lamp});
    wr(ADDR_CTRL, CTRL_RST);
    for (int i = 0; i < 4; i++)
    begin
      {remote_sp_active, alt_sp_active} <= i[1:0];
      cyc(2);
      chk("sp_lamps", i, {external_sp_lamp, alt_sp_lamp});
    end
  endtask : t_lamps

  task automatic t_mode;
    lp1_algo_out <= 16'h1234;
    lp2_algo_out <= 16'h4444;
    kp(0, DB + 4);
    chk("auto_lamp", 32'h0000_0000, open_loop_lamp);
    chk("auto_power", 32'h0000_1234, lp1_power);
    chk("auto_power2", 32'h0000_4444, lp2_power);
    lp1_algo_out <= 16'h2222;
    kp(0, DB + 4);
    lp1_algo_out <= 16'h3333;
    cyc(3);
    chk("man_lamp", 32'h0000_0001, open_loop_lamp);
    chk("mode_store", 32'h0000_0001, mode_store);
    chk("bumpless", 32'h0000_2222, lp1_power);
    wr(ADDR_MANOP, 32'h0000_0055);
    cyc(2);
    chk("man_power", 32'h0000_0055, lp1_power);
    wr(ADDR_CTRL, 32'h0000_0002);
    kp(0, DB + 4);
    chk("key_off", 32'h0000_0001, open_loop_lamp);
    wr(ADDR_CTRL, CTRL_RST);
  endtask : t_mode

  task automatic t_profile_page_key;
    wr(ADDR_CTRL, 32'h0000_0004);
    kp(1, DB + 2);
    chk("start_off", 32'h0000_0000, profile_active_lamp);
    wr(ADDR_CTRL, CTRL_RST);
    kp(1, DB + 2);
    chk("run", 32'h0000_0002, {profile_active_lamp, profile_held_lamp});
    kp(1, DB + 2);
    chk("held", 32'h0000_0001, {profile_active_lamp, profile_held_lamp});
    kp(1, DB + 2);
    profile_page_key_end <= 1'b1;
    comms_active <= 3'b111;
    cyc(1);
    profile_page_key_end <= 1'b0;
    watch(24);
    chk("flash_on", 32'h0000_000F, hi[3:0]);
    chk("flash_off", 32'h0000_000F, lo[3:0]);
    comms_active <= 3'b000;
    kp(1, 60);
    chk("profile_page_key_reset", 32'h0000_0000, {v[2:0], profile_active_lamp, profile_held_lamp});
    rdr(ADDR_STATUS);
    chk("profile_page_key_idle", 32'h0000_0000, rd & 32'h0000_000C);
  endtask : t_profile_page_key

  task automatic t_alarm;
    rdr(ADDR_IRQ);
    wr(ADDR_MASK, 32'h0000_0001);
    alarm_cond <= 1'b1;
    alarm_new <= 1'b1;
    cyc(1);
    alarm_new <= 1'b0;
    watch(24);
    chk("alarm_flash", 32'h0000_0003, {hi[4], lo[4]});
    chk("alarm_msg", 32'h0000_0001, alarm_msg);
    chk("irq_on", 32'h0000_0001, irq);
    rdr(ADDR_IRQ);
    chk("irq_status", 32'h0000_0001, rd[I_ALARM]);
    cyc(3);
    chk("irq_clear", 32'h0000_0000, irq);
    kp(3, DB + 2);
    watch(20);
    chk("ack_steady", 32'h0000_0002, {hi[4], lo[4]});
    chk("ack_msg", 32'h0000_0000, alarm_msg);
    alarm_cond <= 1'b0;
    cyc(3);
    chk("alarm_off", 32'h0000_0000, alarm_lamp);
    wr(ADDR_MASK, MASK_RST);
    alarm_new <= 1'b1;
    cyc(1);
    alarm_new <= 1'b0;
    cyc(4);
    chk("irq_masked", 32'h0000_0000, irq);
    kp(2, DB + 2);
    chk("profile_page_key_page", 32'h0000_0001, profile_page_key_page_shown);
  endtask : t_alarm

  initial
  begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    s_axi_wstrb = 4'hF;
    {lp1_chan_out, lp2_chan_out, soft_src, mode_restore, comms_active} = 11'h000;
    {remote_sp_active, alt_sp_active, alarm_cond, alarm_new, profile_page_key_end, mode_restore_valid} = 6'h00;
    lp1_algo_out = 16'h0000;
    lp2_algo_out = 16'h0000;
    fail_count = 0;
    tests_run = 0;
    cyc(4);
    aresetn <= 1'b1;
    cyc(1);
    t_restore();
    t_lamps();
    t_mode();
    t_profile_page_key();
    t_alarm();
    summarize();
  end
endmodule : front_panel_annunciator_bench

bind fpa_front_panel fpa_props fpa_props_inst (.aclk, .aresetn, .remote_sp_active, .alt_sp_active,
  .external_sp_lamp, .alt_sp_lamp, .alarm_new, .ack_key, .alarm_msg, .comms_active, .first_comms_lamp,
  .mode_store_we, .s_axi_awready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_bvalid, .s_axi_bready);
`default_nettype wire
